// File: core/lsle_defs.vh
`ifndef LSLE_DEFS_VH
`define LSLE_DEFS_VH
// ==========================================================
// register byte addresses (index times four)
`define LSLE_IDX_STATUS 12'h208
`define LSLE_IDX_PWR 12'h209
`define LSLE_IDX_SPARE 12'h20a
`define LSLE_IDX_CTRL 12'h20b
`define LSLE_ADDR_STATUS 14'h0820
`define LSLE_ADDR_PWR 14'h0824
`define LSLE_ADDR_SPARE 14'h0828
`define LSLE_ADDR_CTRL 14'h082c
// ==========================================================
// status fields
`define LSLE_ST_LINK_UP 6
`define LSLE_ST_SYNC 5
`define LSLE_ST_REALIGN 4
`define LSLE_ST_PHASE_SET 3
`define LSLE_ST_PLL_LOCK 2
// ==========================================================
// power-down fields
`define LSLE_PD_B 1
`define LSLE_PD_A 0
// ==========================================================
// control fields (link enable, format, test pattern)
`define LSLE_CT_EN 0
`define LSLE_CT_FMT_LO 8
`define LSLE_CT_FMT_HI 13
`define LSLE_CT_TST_LO 16
`define LSLE_CT_TST_HI 20
// ==========================================================
// reset values and pattern codes
`define LSLE_RST_BYTE 8'h00
`define LSLE_RST_CTRL 32'h00000000
`define LSLE_TST_OFF 5'h00
`define LSLE_TST_RAMP 5'h04
`define LSLE_TST_TRANSPORT 5'h05
`endif

// File: core/lsle_sync3.v
`timescale 1ns/1ps
module lsle_sync3 (
    pclk,
    presetn,
    ce,
    din,
    dout
);
input wire pclk;
input wire presetn;
input wire ce;
input wire din;
output reg dout;
reg s1_r;
reg s2_r;
reg s3_r;
// ==========================================================
// three stages; output follows once stages two and three agree
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        dout <= 1'b0;
    end else if (ce) begin
        s1_r <= din;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
            dout <= s3_r;
        end
    end
end
endmodule

// File: core/lsle_lane_ctl.v
`timescale 1ns/1ps
`include "lsle_defs.vh"
module lsle_lane_ctl (
    link_on,
    base_lanes,
    spare_mask,
    spare_ser_on,
    test_sel,
    lane_clk_en,
    ser_clk_en,
    lane_ramp
);
input wire link_on;
input wire [7:0] base_lanes;
input wire [7:1] spare_mask;
input wire spare_ser_on;
input wire [4:0] test_sel;
output wire [7:0] lane_clk_en;
output wire [7:0] ser_clk_en;
output wire [7:0] lane_ramp;
wire [7:0] want;
wire [7:0] ser_want;
wire ramp_sel;
assign ramp_sel = (test_sel == `LSLE_TST_OFF) || (test_sel == `LSLE_TST_TRANSPORT);
assign want[0] = link_on & base_lanes[0];
assign ser_want[0] = want[0];
assign ser_clk_en[0] = ser_want[0];
assign lane_ramp[0] = 1'b0;
genvar n;
generate
    for (n = 1; n < 8; n = n + 1) begin : g_lane
        // spare lanes only under an enabled, powered link
        assign want[n] = link_on & (base_lanes[n] | spare_mask[n]);
        assign ser_want[n] = link_on & (base_lanes[n] | (spare_mask[n] & spare_ser_on));
        // a serializer is clocked only with all lower lanes on
        assign ser_clk_en[n] = ser_want[n] & (&ser_want[n-1:0]);
        assign lane_ramp[n] = want[n] & ~base_lanes[n] & ramp_sel;
    end
endgenerate
assign lane_clk_en = want;
endmodule

// File: core/lsle_top.v
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "lsle_defs.vh"
module lsle_top (
    pclk,
    presetn,
    ce,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    pstrb,
    prdata,
    pready,
    pslverr,
    sync_req_n,
    pll_locked,
    link_established,
    sysref_phase_shift,
    sysref_event,
    base_lanes,
    chan_a_bound,
    chan_b_bound,
    chan_a_power_off,
    chan_b_power_off,
    dig_chan_power_off,
    link_power_off,
    link_enable,
    link_format_select,
    link_test_pattern_select,
    lane_clk_en,
    ser_clk_en,
    lane_ramp
);
input wire pclk;
input wire presetn;
input wire ce;
input wire psel;
input wire penable;
input wire pwrite;
input wire [13:0] paddr;
input wire [31:0] pwdata;
input wire [3:0] pstrb;
output reg [31:0] prdata;
output wire pready;
output wire pslverr;
input wire sync_req_n;
input wire pll_locked;
input wire link_established;
input wire sysref_phase_shift;
input wire sysref_event;
input wire [7:0] base_lanes;
input wire [3:0] chan_a_bound;
input wire [3:0] chan_b_bound;
output reg chan_a_power_off;
output reg chan_b_power_off;
output reg [3:0] dig_chan_power_off;
output reg link_power_off;
output wire link_enable;
output wire [5:0] link_format_select;
output wire [4:0] link_test_pattern_select;
output wire [7:0] lane_clk_en;
output wire [7:0] ser_clk_en;
output wire [7:0] lane_ramp;

reg [1:0] pwr_r;
reg [7:0] spare_r;
reg [31:0] ctrl_r;
reg realign_r;
reg realign_nxt;
reg phase_set_r;
reg phase_set_nxt;
reg armed_r;
reg en_d_r;
reg [31:0] rd_nxt;
wire sync_s;
wire lock_s;
wire up_s;
wire wr_acc;
wire rd_acc;
wire hit_status;
wire hit_pwr;
wire hit_spare;
wire hit_ctrl;
wire hit_any;
wire [7:0] status_val;

// ==========================================================
// pin synchronisers for link-side levels
lsle_sync3 u_sync_req (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(sync_req_n),
    .dout(sync_s)
);
lsle_sync3 u_pll (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(pll_locked),
    .dout(lock_s)
);
lsle_sync3 u_up (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(link_established),
    .dout(up_s)
);

// ==========================================================
// apb decode; zero wait states, unmapped addresses give pslverr
assign pready = 1'b1;
assign hit_status = (paddr == `LSLE_ADDR_STATUS);
assign hit_pwr = (paddr == `LSLE_ADDR_PWR);
assign hit_spare = (paddr == `LSLE_ADDR_SPARE);
assign hit_ctrl = (paddr == `LSLE_ADDR_CTRL);
assign hit_any = hit_status | hit_pwr | hit_spare | hit_ctrl;
assign pslverr = psel & penable & ~hit_any;
assign wr_acc = ce & psel & penable & pwrite & hit_any;
assign rd_acc = ce & psel & ~penable & ~pwrite;

// live bits read current condition; writes cannot reach them
assign status_val = {1'b0, up_s, sync_s, realign_r, phase_set_r, lock_s, 2'b00};

always @* begin
    rd_nxt = 32'h00000000;
    if (hit_status) begin
        rd_nxt = {24'h000000, status_val};
    end else if (hit_pwr) begin
        rd_nxt = {30'h00000000, pwr_r};
    end else if (hit_spare) begin
        rd_nxt = {24'h000000, spare_r};
    end else if (hit_ctrl) begin
        rd_nxt = ctrl_r;
    end
end

// ==========================================================
// sticky sysref flags; a new event wins over a same-cycle clear
always @* begin
    realign_nxt = realign_r;
    phase_set_nxt = phase_set_r;
    if (wr_acc && hit_status && pstrb[0]) begin
        if (pwdata[`LSLE_ST_REALIGN]) begin
            realign_nxt = 1'b0;
        end
        if (pwdata[`LSLE_ST_PHASE_SET]) begin
            phase_set_nxt = 1'b0;
        end
    end
    if (sysref_phase_shift && !link_power_off) begin
        realign_nxt = 1'b1;
    end
    if (sysref_event && armed_r && !link_power_off) begin
        phase_set_nxt = 1'b1;
    end
end

// ==========================================================
// register file
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pwr_r <= 2'b00;
        spare_r <= `LSLE_RST_BYTE;
        ctrl_r <= `LSLE_RST_CTRL;
        realign_r <= 1'b0;
        phase_set_r <= 1'b0;
        armed_r <= 1'b0;
        en_d_r <= 1'b0;
        prdata <= 32'h00000000;
    end else if (ce) begin
        realign_r <= realign_nxt;
        phase_set_r <= phase_set_nxt;
        en_d_r <= ctrl_r[`LSLE_CT_EN];
        // arm on encoder enable, disarm after first sysref
        if (ctrl_r[`LSLE_CT_EN] && !en_d_r) begin
            armed_r <= 1'b1;
        end else if (!ctrl_r[`LSLE_CT_EN] || (sysref_event && !link_power_off)) begin
            armed_r <= 1'b0;
        end
        if (rd_acc) begin
            prdata <= rd_nxt;
        end
        if (wr_acc && pstrb[0]) begin
            if (hit_pwr) begin
                pwr_r <= pwdata[1:0];
            end
            if (hit_spare) begin
                spare_r <= pwdata[7:0];
            end
            if (hit_ctrl) begin
                ctrl_r[7:0] <= pwdata[7:0];
            end
        end
        if (wr_acc && hit_ctrl) begin
            if (pstrb[1]) begin
                ctrl_r[15:8] <= pwdata[15:8];
            end
            if (pstrb[2]) begin
                ctrl_r[23:16] <= pwdata[23:16];
            end
            if (pstrb[3]) begin
                ctrl_r[31:24] <= pwdata[31:24];
            end
        end
    end
end

assign link_enable = ctrl_r[`LSLE_CT_EN];
assign link_format_select = ctrl_r[`LSLE_CT_FMT_HI:`LSLE_CT_FMT_LO];
assign link_test_pattern_select = ctrl_r[`LSLE_CT_TST_HI:`LSLE_CT_TST_LO];

// ==========================================================
// power-down outputs, registered
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        chan_a_power_off <= 1'b0;
        chan_b_power_off <= 1'b0;
        dig_chan_power_off <= 4'h0;
        link_power_off <= 1'b0;
    end else if (ce) begin
        chan_a_power_off <= pwr_r[`LSLE_PD_A];
        chan_b_power_off <= pwr_r[`LSLE_PD_B];
        // a bound digital channel follows its converter; the link stays up unless both converters are off
        dig_chan_power_off <= ({4{pwr_r[`LSLE_PD_A]}} & chan_a_bound)
            | ({4{pwr_r[`LSLE_PD_B]}} & chan_b_bound);
        link_power_off <= pwr_r[`LSLE_PD_A] & pwr_r[`LSLE_PD_B];
    end
end

// ==========================================================
// lane and serializer enables
lsle_lane_ctl u_lanes (
    .link_on(ctrl_r[`LSLE_CT_EN] & ~link_power_off),
    .base_lanes(base_lanes),
    .spare_mask(spare_r[7:1]),
    .spare_ser_on(spare_r[0]),
    .test_sel(ctrl_r[`LSLE_CT_TST_HI:`LSLE_CT_TST_LO]),
    .lane_clk_en(lane_clk_en),
    .ser_clk_en(ser_clk_en),
    .lane_ramp(lane_ramp)
);

endmodule

// File: verif/lsle_top_monitor.sv
`timescale 1ns/1ps
`include "lsle_defs.vh"
module lsle_top_monitor (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire sync_req_n,
    input wire pll_locked,
    input wire link_established,
    input wire [7:0] base_lanes,
    input wire [3:0] chan_a_bound,
    input wire [3:0] chan_b_bound,
    input wire chan_a_power_off,
    input wire chan_b_power_off,
    input wire [3:0] dig_chan_power_off,
    input wire link_power_off,
    input wire link_enable,
    input wire [4:0] link_test_pattern_select,
    input wire [7:0] lane_clk_en,
    input wire [7:0] ser_clk_en,
    input wire [7:0] lane_ramp
);
// ========
// checks
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
sequence s_live_steady;
    (ce && $stable(link_established) && $stable(sync_req_n) && $stable(pll_locked))[*6];
endsequence
sequence s_status_read;
    psel && !penable && !pwrite && paddr == `LSLE_ADDR_STATUS;
endsequence
a_live_status: assert property (s_live_steady ##0 s_status_read |=>
    prdata[6:5] == {link_established, sync_req_n} && prdata[2] == pll_locked)
    else $error("live status bits wrong");
a_pd_joint: assert property (link_power_off == (chan_a_power_off && chan_b_power_off))
    else $error("link power-off wrong");
a_dig_match: assert property ($stable(chan_a_bound) && $stable(chan_b_bound) |->
    dig_chan_power_off == ((chan_a_bound & {4{chan_a_power_off}})
    | (chan_b_bound & {4{chan_b_power_off}}))) else $error("digital power-off wrong");
a_ser_chain: assert property ((ser_clk_en[7:1] & ~ser_clk_en[6:0]) == 7'h00)
    else $error("serializer clocked without lower lanes");
a_ser_sub: assert property ((ser_clk_en & ~lane_clk_en) == 8'h00)
    else $error("serializer without lane clock");
a_ramp_only: assert property (lane_ramp != 8'h00 |-> !lane_ramp[0]
    && (lane_ramp & base_lanes) == 8'h00 && (link_test_pattern_select == `LSLE_TST_OFF
    || link_test_pattern_select == `LSLE_TST_TRANSPORT)) else $error("ramp lane wrong");
a_spare_gate: assert property (!link_enable |-> (lane_clk_en & ~base_lanes) == 8'h00)
    else $error("extra lane on while link off");
a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule
bind lsle_top lsle_top_monitor mon_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .sync_req_n(sync_req_n), .pll_locked(pll_locked), .link_established(link_established),
    .base_lanes(base_lanes), .chan_a_bound(chan_a_bound), .chan_b_bound(chan_b_bound),
    .chan_a_power_off(chan_a_power_off), .chan_b_power_off(chan_b_power_off),
    .dig_chan_power_off(dig_chan_power_off), .link_power_off(link_power_off),
    .link_enable(link_enable), .link_test_pattern_select(link_test_pattern_select),
    .lane_clk_en(lane_clk_en), .ser_clk_en(ser_clk_en), .lane_ramp(lane_ramp));

// File: verif/lsle_rx_model.sv
`timescale 1ns/1ps
module lsle_rx_model (
    input wire pclk,
    input wire presetn,
    input wire link_enable,
    input wire link_power_off,
    input wire slow,
    output reg sync_req_n,
    output reg link_established
);
// ========
// receiver holds sync request until lanes settle
reg [4:0] cnt_r;
always @(posedge pclk or negedge presetn) begin
    if (!presetn || !link_enable || link_power_off) begin
        cnt_r <= 5'h00;
        sync_req_n <= 1'b0;
        link_established <= 1'b0;
    end else if (cnt_r != (slow ? 5'h14 : 5'h04)) begin
        cnt_r <= cnt_r + 5'h01;
    end else begin
        sync_req_n <= 1'b1;
        link_established <= 1'b1;
    end
end
endmodule

// File: verif/test_link_status_lane_enable.sv
`timescale 1ns/1ps
`include "lsle_defs.vh"
module test_link_status_lane_enable;
reg pclk, presetn, psel, penable, pwrite, sr_shift, sr_event, pll_locked, slow, ce;
wire [5:0] fmt;
reg [13:0] paddr;
reg [31:0] pwdata, r;
reg [7:0] base, ext, s, se;
reg [4:0] tpv [0:2] = '{5'h00, 5'h04, 5'h05};
reg [2:0] k;
integer fails, checked, n;
reg [32:0] exp_q[$];
wire [31:0] prdata;
wire pready, pslverr, sync_req_n, link_up, a_off, b_off, link_off, link_enable;
wire [3:0] dig_off;
wire [4:0] tp_sel;
wire [7:0] lane_clk_en, ser_clk_en, lane_ramp;
lsle_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_req_n(sync_req_n), .pll_locked(pll_locked),
    .link_established(link_up), .sysref_phase_shift(sr_shift), .sysref_event(sr_event),
    .base_lanes(base), .chan_a_bound(4'h3), .chan_b_bound(4'hc), .chan_a_power_off(a_off),
    .chan_b_power_off(b_off), .dig_chan_power_off(dig_off), .link_power_off(link_off),
    .link_enable(link_enable), .link_format_select(fmt), .link_test_pattern_select(tp_sel),
    .lane_clk_en(lane_clk_en), .ser_clk_en(ser_clk_en), .lane_ramp(lane_ramp));
lsle_rx_model rx_u (.pclk(pclk), .presetn(presetn), .link_enable(link_enable),
    .link_power_off(link_off), .slow(slow), .sync_req_n(sync_req_n), .link_established(link_up));
// ========
// tasks
task stop_test;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
task chk(input string nm, input [32:0] e, input [32:0] v);
    checked++;
    if (v !== e) begin
        fails++;
        $display("MISMATCH %0s exp %h got %h", nm, e, v);
    end
endtask
task apb(input w, input [13:0] a, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin
        @(posedge pclk);
        n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
        fails++;
        stop_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
task rd(input [13:0] a, input [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
endtask
task pulse(input ev);
    if (ev) sr_event <= 1'b1;
    else sr_shift <= 1'b1;
    @(posedge pclk) {sr_event, sr_shift} <= 2'b00;
    @(posedge pclk);
endtask
// ========
// read watcher
always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
    if (exp_q.size() == 0) chk("read note", 33'h1, 33'h0);
    else chk("read", exp_q.pop_front(), {pslverr, prdata});
end
initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    stop_test;
end
initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
end
// ========
// main sequence
initial begin
    {fails, checked} = 0;
    {presetn, psel, penable, pwrite, sr_shift, sr_event, pll_locked, slow} = 8'h00;
    {paddr, pwdata, base} = 0;
    ce = 1'b1;
    r = $urandom(52);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`LSLE_ADDR_STATUS, 33'h0);
    rd(`LSLE_ADDR_PWR, 33'h0);
    rd(`LSLE_ADDR_SPARE, 33'h0);
    rd(14'h0900, {1'b1, 32'h0});
    pll_locked <= 1'b1;
    for (k = 0; k < 2; k++) begin
        slow <= k[0];
        apb(1'b1, `LSLE_ADDR_CTRL, 32'h1);
        for (n = 0; n < 100 && !link_up; n++) @(posedge pclk);
        if (!link_up) chk("link up", 33'h1, 33'h0);
        repeat (6) @(posedge pclk);
        rd(`LSLE_ADDR_STATUS, 33'h64);
        apb(1'b1, `LSLE_ADDR_STATUS, 32'hff);
        rd(`LSLE_ADDR_STATUS, 33'h64);
        pulse(1'b1);
        pulse(1'b0);
        rd(`LSLE_ADDR_STATUS, 33'h7c);
        apb(1'b1, `LSLE_ADDR_STATUS, 32'h10);
        rd(`LSLE_ADDR_STATUS, 33'h6c);
        apb(1'b1, `LSLE_ADDR_STATUS, 32'h0);
        rd(`LSLE_ADDR_STATUS, 33'h6c);
        apb(1'b1, `LSLE_ADDR_STATUS, 32'h08);
        pulse(1'b1);
        rd(`LSLE_ADDR_STATUS, 33'h64);
        apb(1'b1, `LSLE_ADDR_CTRL, 32'h0);
    end
    // a write while the clock enable is low must not land
    ce <= 1'b0;
    apb(1'b1, `LSLE_ADDR_PWR, 32'h3);
    ce <= 1'b1;
    rd(`LSLE_ADDR_PWR, 33'h0);
    // calibration is outside this block, so each power-down setting is written and checked at once
    for (k = 0; k < 4; k++) begin
        apb(1'b1, `LSLE_ADDR_PWR, {30'h0, k[1:0]});
        rd(`LSLE_ADDR_PWR, {31'h0, k[1:0]});
        chk("pd", {k == 3, (k[0] ? 4'h3 : 4'h0) | (k[1] ? 4'hc : 4'h0), k[1:0]},
            {link_off, dig_off, b_off, a_off});
    end
    apb(1'b1, `LSLE_ADDR_PWR, 32'h0);
    for (k = 0; k < 6; k++) begin
        r = $urandom;
        base <= (k > 2) ? 8'h03 : 8'h01;
        apb(1'b1, `LSLE_ADDR_SPARE, {24'h0, r[7:0]});
        apb(1'b1, `LSLE_ADDR_CTRL, {11'h0, tpv[k % 3], 2'b00, r[13:8], 8'h01});
        chk("ctrl out", {1'b1, r[13:8], tpv[k % 3]}, {link_enable, fmt, tp_sel});
        rd(`LSLE_ADDR_CTRL, {12'h0, tpv[k % 3], 2'b00, r[13:8], 8'h01});
        ext = {r[7:1], 1'b0};
        s = base | (r[0] ? ext : 8'h00);
        se[0] = s[0];
        for (n = 1; n < 8; n++) se[n] = se[n - 1] & s[n];
        chk("lanes", {base | ext, se, (k % 3 == 1) ? 8'h00 : ext & ~base},
            {lane_clk_en, ser_clk_en, lane_ramp});
        rd(`LSLE_ADDR_SPARE, {25'h0, r[7:0]});
        apb(1'b1, `LSLE_ADDR_CTRL, 32'h0);
    end
    stop_test;
end
endmodule
